// file: hdl/stp_params.svh
// register offsets, field positions, reset values and timing counts of the chopper config block
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

`define STP_AW 8
`define STP_ADDR_PWMCONF 8'h3C
`define STP_ADDR_CTRL 8'h40
`define STP_ADDR_DRVSTAT 8'h44
`define STP_ADDR_IRQSTAT 8'h48
`define STP_ADDR_IRQMASK 8'h4C
`define STP_ADDR_LIMITS 8'h50

`define STP_PWMCONF_RST 32'hC40C_001D
`define STP_CTRL_RST 32'h0000_0000
`define STP_LIMITS_RST 32'h0000_0000

`define STP_F_LIM_HI 31
`define STP_F_LIM_LO 28
`define STP_F_REG_HI 27
`define STP_F_REG_LO 24
`define STP_F_DIS_REG 23
`define STP_F_SD_MEAS 22
`define STP_F_HOLD_HI 21
`define STP_F_HOLD_LO 20
`define STP_F_AUTOGRAD 19
`define STP_F_AUTOSCALE 18
`define STP_F_FREQ_HI 17
`define STP_F_FREQ_LO 16
`define STP_F_SLOPE_HI 15
`define STP_F_SLOPE_LO 8
`define STP_F_OFS_HI 7
`define STP_F_OFS_LO 0

`define STP_S_SHORT_A 12
`define STP_S_STALL 24
`define STP_S_LOAD_HI 9
`define STP_S_LOAD_LO 0

`define STP_C_OFF_TIME_SETTING_HI 3
`define STP_C_OFF_TIME_SETTING_LO 0
`define STP_C_DRV_DIS 4

`define STP_I_SHORT 0
`define STP_I_STALL 1

`define STP_PWM_DIV0 11'h400
`define STP_PWM_DIV1 11'h2AB
`define STP_PWM_DIV2 11'h200
`define STP_PWM_DIV3 11'h19A

`endif

// file: hdl/stp_pkg.sv
// types shared by the chopper config block
package stp_pkg;
    typedef enum logic [1:0] {
        STP_HOLD_NORMAL,
        STP_HOLD_HOLD_ZERO_COIL_MODE,
        STP_HOLD_SHORT_LS,
        STP_HOLD_SHORT_HS
    } stp_hold_mode_t;
    typedef enum logic [1:0] {
        STP_AMP_USER,
        STP_AMP_AUTO,
        STP_AMP_SWITCHBACK
    } stp_amp_state_t;
endpackage

// file: hdl/stp_amp_ctrl.sv
// amplitude and slope path of the quiet chopper
`timescale 1ns/1ps
`include "stp_params.svh"
module stp_amp_ctrl
    import stp_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // configuration
    input wire logic autoscale_i,
    input wire logic autograd_i,
    input wire logic [3:0] limit_i,
    input wire logic [3:0] reg_grad_i,
    input wire logic [7:0] offset_i,
    input wire logic [7:0] slope_i,
    // motor state
    input wire logic [4:0] cs_actual_i,
    input wire logic [19:0] step_interval_i,
    input wire logic [7:0] auto_amp_i,
    input wire logic [7:0] auto_slope_i,
    input wire logic halfwave_i,
    input wire logic switch_back_i,
    // results
    output logic [7:0] amp_o,
    output logic [7:0] slope_o,
    output stp_amp_state_t state_o
);
    logic [8:0] amp_half_q; // amplitude in half increments
    logic [8:0] amp_half_d;
    logic [7:0] user_amp;
    logic [13:0] ofs_part;
    logic [19:0] grad_part;
    logic [20:0] user_sum;
    logic [7:0] capped;
    logic [4:0] step_half;
    logic [8:0] target_half;

    // user feed-forward amplitude, clamped to 0..255
    always_comb begin
        ofs_part = 14'(({6'h00, offset_i} * {9'h000, cs_actual_i}) + {6'h00, offset_i});
        grad_part = (step_interval_i == 20'h0_0000) ? 20'h0_0000 : 20'({slope_i, 8'h00} / step_interval_i);
        user_sum = 21'(ofs_part >> 5) + {1'b0, grad_part};
        user_amp = (user_sum > 21'h00_00FF) ? 8'hFF : user_sum[7:0];
    end

    // switch-back cap on bits 7..4 of the auto value
    assign capped = (auto_amp_i[7:4] > limit_i) ? {limit_i, auto_amp_i[3:0]} : auto_amp_i;
    // code 0 is illegal, it is run as the slowest step
    assign step_half = (reg_grad_i == 4'h0) ? 5'h01 : {1'b0, reg_grad_i};
    assign target_half = {auto_amp_i, 1'b0};

    // regulated amplitude moves by at most the step per half wave; switch-back loads the capped value at once
    always_comb begin
        amp_half_d = amp_half_q;
        if (!autoscale_i) begin
            amp_half_d = {user_amp, 1'b0};
        end else if (switch_back_i) begin
            amp_half_d = {capped, 1'b0};
        end else if (halfwave_i) begin
            if (target_half > amp_half_q + 9'(step_half)) begin
                amp_half_d = amp_half_q + 9'(step_half);
            end else if (amp_half_q > target_half + 9'(step_half)) begin
                amp_half_d = amp_half_q - 9'(step_half);
            end else begin
                amp_half_d = target_half;
            end
        end
    end

    // amplitude register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            amp_half_q <= 9'h000;
        end else if (ce_i) begin
            amp_half_q <= amp_half_d;
        end
    end

    // tuned slope is never limited by the switch-back cap
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            slope_o <= 8'h00;
            state_o <= STP_AMP_AUTO;
        end else if (ce_i) begin
            slope_o <= (autoscale_i && autograd_i) ? auto_slope_i : slope_i;
            if (!autoscale_i) begin
                state_o <= STP_AMP_USER;
            end else if (switch_back_i) begin
                state_o <= STP_AMP_SWITCHBACK;
            end else begin
                state_o <= STP_AMP_AUTO;
            end
        end
    end

    assign amp_o = amp_half_q[8:1];
endmodule

// file: hdl/stp_pwm_cfg.sv
// one axis: quiet chopper configuration word, short and load status, interrupt
`timescale 1ns/1ps
`include "stp_params.svh"
module stp_pwm_cfg
    import stp_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register port
    input wire logic [`STP_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // bridge and motion state
    input wire logic short_det_a_i,
    input wire logic [9:0] load_meas_i,
    input wire logic load_vld_i,
    input wire logic [9:0] ontime_a_i,
    input wire logic standstill_i,
    input wire logic below_run_i,
    input wire logic hold_zero_i,
    input wire logic quiet_active_i,
    input wire logic [4:0] cs_actual_i,
    input wire logic [19:0] step_interval_i,
    input wire logic [7:0] auto_amp_i,
    input wire logic [7:0] auto_slope_i,
    input wire logic halfwave_i,
    input wire logic switch_back_i,
    // chopper controls
    output logic driver_en_o,
    output stp_hold_mode_t hold_mode_o,
    output logic reg_suspend_o,
    output logic sd_measure_o,
    output logic pwm_tick_o,
    output logic [7:0] amp_o,
    output logic [7:0] slope_o,
    output stp_amp_state_t amp_state_o,
    // load and interrupt
    output logic stall_o,
    output logic load_low_o,
    output logic load_high_o,
    output logic irq_o
);
    logic [31:0] pwmconf_q;
    logic [31:0] ctrl_q;
    logic [31:0] limits_q;
    logic [1:0] irq_sts_q;
    logic [1:0] irq_sts_d;
    logic [1:0] irq_mask_q;
    logic short_flag_a_q;
    logic short_flag_a_d;
    logic [9:0] load_result_q;
    logic stall_d;
    logic sw_off;
    logic wr_pwm;
    logic wr_ctrl;
    logic [10:0] pwm_cnt_q;
    logic [10:0] pwm_div;
    logic [31:0] rd_mux;

    // write decode
    assign wr_pwm = wr_i && (addr_i == `STP_ADDR_PWMCONF);
    assign wr_ctrl = wr_i && (addr_i == `STP_ADDR_CTRL);

    // configuration word, every field read-write
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pwmconf_q <= `STP_PWMCONF_RST;
        end else if (ce_i && wr_pwm) begin
            pwmconf_q <= wdata_i;
        end
    end

    // own controls and load limits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `STP_CTRL_RST;
            limits_q <= `STP_LIMITS_RST;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_q <= {27'h000_0000, wdata_i[`STP_C_DRV_DIS:0]};
            end
            if (wr_i && (addr_i == `STP_ADDR_LIMITS)) begin
                limits_q <= {6'h00, wdata_i[25:16], 6'h00, wdata_i[9:0]};
            end
        end
    end

    // software off: off-time zero or disable set
    assign sw_off = (ctrl_q[`STP_C_OFF_TIME_SETTING_HI:`STP_C_OFF_TIME_SETTING_LO] == 4'h0) || ctrl_q[`STP_C_DRV_DIS];

    // short flag: detection wins over the software clear
    always_comb begin
        short_flag_a_d = short_flag_a_q;
        if (sw_off) begin
            short_flag_a_d = 1'b0;
        end
        if (short_det_a_i) begin
            short_flag_a_d = 1'b1;
        end
    end

    // stall when a valid measurement reads zero in motion outside the quiet chopper
    assign stall_d = load_vld_i && !standstill_i && !quiet_active_i && (load_meas_i == 10'h000);

    // load field: measurement in motion, coil-A on-time at standstill
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            load_result_q <= 10'h000;
            stall_o <= 1'b0;
            load_low_o <= 1'b0;
            load_high_o <= 1'b0;
        end else if (ce_i) begin
            if (standstill_i) begin
                load_result_q <= ontime_a_i;
                stall_o <= 1'b0;
                load_low_o <= 1'b0;
                load_high_o <= 1'b0;
            end else if (load_vld_i) begin
                load_result_q <= load_meas_i;
                stall_o <= stall_d;
                // limit compare only outside the quiet chopper
                load_low_o <= !quiet_active_i && (load_meas_i < limits_q[9:0]);
                load_high_o <= !quiet_active_i && (load_meas_i > limits_q[25:16]);
            end
        end
    end

    // flag and bridge enable
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            short_flag_a_q <= 1'b0;
            driver_en_o <= 1'b0;
        end else if (ce_i) begin
            short_flag_a_q <= short_flag_a_d;
            driver_en_o <= !short_flag_a_d && !sw_off;
        end
    end

    // sticky events: set wins over write-one-to-clear
    always_comb begin
        irq_sts_d = irq_sts_q;
        if (wr_i && (addr_i == `STP_ADDR_IRQSTAT)) begin
            irq_sts_d = irq_sts_q & ~wdata_i[1:0];
        end
        irq_sts_d[`STP_I_SHORT] = irq_sts_d[`STP_I_SHORT] | (short_det_a_i && !short_flag_a_q);
        irq_sts_d[`STP_I_STALL] = irq_sts_d[`STP_I_STALL] | stall_d;
    end

    // interrupt status, mask and level output
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_sts_q <= 2'b00;
            irq_mask_q <= 2'b00;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_sts_q <= irq_sts_d;
            if (wr_i && (addr_i == `STP_ADDR_IRQMASK)) begin
                irq_mask_q <= wdata_i[1:0];
                irq_o <= |(irq_sts_d & wdata_i[1:0]);
            end else begin
                irq_o <= |(irq_sts_d & irq_mask_q);
            end
        end
    end

    // standstill controls
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_suspend_o <= 1'b0;
            sd_measure_o <= 1'b0;
            hold_mode_o <= STP_HOLD_NORMAL;
        end else if (ce_i) begin
            reg_suspend_o <= pwmconf_q[`STP_F_DIS_REG] && standstill_i && below_run_i;
            sd_measure_o <= pwmconf_q[`STP_F_SD_MEAS];
            if (hold_zero_i && standstill_i) begin
                hold_mode_o <= stp_hold_mode_t'(pwmconf_q[`STP_F_HOLD_HI:`STP_F_HOLD_LO]);
            end else begin
                hold_mode_o <= STP_HOLD_NORMAL;
            end
        end
    end

    // chopper period in clocks, two ticks per period
    always_comb begin
        case (pwmconf_q[`STP_F_FREQ_HI:`STP_F_FREQ_LO])
            2'd0: pwm_div = `STP_PWM_DIV0;
            2'd1: pwm_div = `STP_PWM_DIV1;
            2'd2: pwm_div = `STP_PWM_DIV2;
            default: pwm_div = `STP_PWM_DIV3;
        endcase
    end

    // rate counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pwm_cnt_q <= 11'h000;
            pwm_tick_o <= 1'b0;
        end else if (ce_i) begin
            pwm_cnt_q <= (pwm_cnt_q >= pwm_div - 11'h001) ? 11'h000 : pwm_cnt_q + 11'h001;
            pwm_tick_o <= (pwm_cnt_q == 11'h000) || (pwm_cnt_q == (pwm_div >> 1));
        end
    end

    // amplitude and slope path
    stp_amp_ctrl u_amp (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .autoscale_i(pwmconf_q[`STP_F_AUTOSCALE]),
        .autograd_i(pwmconf_q[`STP_F_AUTOGRAD]),
        .limit_i(pwmconf_q[`STP_F_LIM_HI:`STP_F_LIM_LO]),
        .reg_grad_i(pwmconf_q[`STP_F_REG_HI:`STP_F_REG_LO]),
        .offset_i(pwmconf_q[`STP_F_OFS_HI:`STP_F_OFS_LO]),
        .slope_i(pwmconf_q[`STP_F_SLOPE_HI:`STP_F_SLOPE_LO]),
        .cs_actual_i(cs_actual_i),
        .step_interval_i(step_interval_i),
        .auto_amp_i(auto_amp_i),
        .auto_slope_i(auto_slope_i),
        .halfwave_i(halfwave_i),
        .switch_back_i(switch_back_i),
        .amp_o(amp_o),
        .slope_o(slope_o),
        .state_o(amp_state_o)
    );

    // read mux, unmapped reads zero; no read side effects
    always_comb begin
        if (addr_i == `STP_ADDR_PWMCONF) begin
            rd_mux = pwmconf_q;
        end else if (addr_i == `STP_ADDR_CTRL) begin
            rd_mux = ctrl_q;
        end else if (addr_i == `STP_ADDR_DRVSTAT) begin
            rd_mux = 32'h0000_0000;
            rd_mux[`STP_S_SHORT_A] = short_flag_a_q;
            rd_mux[`STP_S_STALL] = stall_o;
            rd_mux[`STP_S_LOAD_HI:`STP_S_LOAD_LO] = load_result_q;
        end else if (addr_i == `STP_ADDR_IRQSTAT) begin
            rd_mux = {30'h0000_0000, irq_sts_q};
        end else if (addr_i == `STP_ADDR_IRQMASK) begin
            rd_mux = {30'h0000_0000, irq_mask_q};
        end else if (addr_i == `STP_ADDR_LIMITS) begin
            rd_mux = limits_q;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence short_seen_s;
        ce_i && short_det_a_i;
    endsequence

    sequence flag_held_s;
        short_flag_a_q && !driver_en_o;
    endsequence

    short_sets_flag_a: assert property (short_seen_s |=> flag_held_s)
        else $error("short did not set flag and stop bridge");
    flag_holds_a: assert property (ce_i && short_flag_a_q && !sw_off |=> short_flag_a_q)
        else $error("short flag dropped without software off");
    flag_clears_a: assert property (ce_i && sw_off && !short_det_a_i |=> !short_flag_a_q)
        else $error("short flag not cleared by software off");
    load_field_a: assert property (ce_i && !standstill_i && load_vld_i |=> load_result_q == $past(load_meas_i))
        else $error("load field not updated");
    stall_zero_a: assert property (ce_i && !standstill_i && load_vld_i && !quiet_active_i
        && load_meas_i == 10'h000 |=> stall_o)
        else $error("zero load did not flag stall");
    quiet_no_cmp_a: assert property (ce_i && load_vld_i && quiet_active_i |=> !load_low_o && !load_high_o)
        else $error("limit compare active in quiet chopper");
    standstill_ontime_a: assert property (ce_i && standstill_i |=> load_result_q == $past(ontime_a_i))
        else $error("on-time not shown at standstill");
    suspend_reg_a: assert property (ce_i |=> reg_suspend_o == ($past(pwmconf_q[23]) && $past(standstill_i)
        && $past(below_run_i)))
        else $error("standstill regulation control wrong");
    read_back_a: assert property (ce_i && wr_pwm ##1 ce_i && rd_i && addr_i == `STP_ADDR_PWMCONF && !wr_i
        |=> rdata_o == $past(wdata_i, 2))
        else $error("config word read back differs");
    pwm_period_a: assert property (ce_i && pwm_cnt_q == 11'h000 |=> pwm_tick_o)
        else $error("no tick at start of chopper period");
endmodule

// file: test/stp_motor_model.sv
// bridge and motor side model: short detect, load results, coil-A on-time, motion state
`timescale 1ns/1ps
module stp_motor_model (
    // clock
    input wire logic core_clk_i,
    // towards the config block
    output logic short_det_a_o,
    output logic [9:0] load_meas_o,
    output logic load_vld_o,
    output logic [9:0] ontime_a_o,
    output logic standstill_o,
    output logic below_run_o,
    output logic hold_zero_o,
    output logic quiet_active_o
);
    // no short, moving motor outside the quiet chopper at time zero
    initial begin
        short_det_a_o = 1'b0;
        load_meas_o = 10'h000;
        load_vld_o = 1'b0;
        ontime_a_o = 10'h2A5;
        standstill_o = 1'b0;
        below_run_o = 1'b0;
        hold_zero_o = 1'b0;
        quiet_active_o = 1'b0;
    end

    // one-cycle short to supply on phase A
    task automatic short_pulse();
        @(posedge core_clk_i);
        short_det_a_o <= 1'b1;
        @(posedge core_clk_i);
        short_det_a_o <= 1'b0;
    endtask

    // one load result; the released bus shows the inverse so stale data never looks valid
    task automatic send_load(input logic [9:0] v);
        @(posedge core_clk_i);
        load_meas_o <= v;
        load_vld_o <= 1'b1;
        @(posedge core_clk_i);
        load_meas_o <= ~v;
        load_vld_o <= 1'b0;
    endtask

    // standstill, reduced current, zero hold current, quiet chopper
    task automatic set_state(input logic ss, input logic br, input logic hz, input logic qa);
        @(posedge core_clk_i);
        standstill_o <= ss;
        below_run_o <= br;
        hold_zero_o <= hz;
        quiet_active_o <= qa;
    endtask
endmodule

// file: test/stepper_pwm_chopper_config_bench.sv
// self-checking bench for the chopper config block
`timescale 1ns/1ps
`include "stp_params.svh"
module stepper_pwm_chopper_config_bench;
    import stp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [4:0] cs = 5'h00;
    logic [19:0] step_interval = 20'h0_0000;
    logic [7:0] auto_amp = 8'h00;
    logic [7:0] auto_slope = 8'h00;
    logic hw = 1'b0;
    logic sb = 1'b0;
    logic short_det, load_vld, standstill, below_run, hold_zero, quiet;
    logic [9:0] load_meas, ontime;
    logic [31:0] rdata, d;
    logic drv_en, reg_susp, sd_meas, tick, stall, ld_low, ld_high, irq;
    logic [7:0] amp, slope;
    stp_hold_mode_t hold_mode;
    stp_amp_state_t amp_state;
    int bad_count = 0;
    int num_checks = 0;

    stp_motor_model mot (.core_clk_i(clk), .short_det_a_o(short_det), .load_meas_o(load_meas),
        .load_vld_o(load_vld), .ontime_a_o(ontime), .standstill_o(standstill), .below_run_o(below_run),
        .hold_zero_o(hold_zero), .quiet_active_o(quiet));

    stp_pwm_cfg dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .short_det_a_i(short_det), .load_meas_i(load_meas),
        .load_vld_i(load_vld), .ontime_a_i(ontime), .standstill_i(standstill), .below_run_i(below_run),
        .hold_zero_i(hold_zero), .quiet_active_i(quiet), .cs_actual_i(cs), .step_interval_i(step_interval),
        .auto_amp_i(auto_amp), .auto_slope_i(auto_slope), .halfwave_i(hw), .switch_back_i(sb),
        .driver_en_o(drv_en), .hold_mode_o(hold_mode), .reg_suspend_o(reg_susp), .sd_measure_o(sd_meas),
        .pwm_tick_o(tick), .amp_o(amp), .slope_o(slope), .amp_state_o(amp_state), .stall_o(stall),
        .load_low_o(ld_low), .load_high_o(ld_high), .irq_o(irq));

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // register bus: one-cycle write and read strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    // one-cycle pulse on half-wave or switch-back
    task automatic pls(input bit half);
        @(posedge clk);
        if (half) begin
            hw <= 1'b1;
        end else begin
            sb <= 1'b1;
        end
        @(posedge clk);
        hw <= 1'b0;
        sb <= 1'b0;
    endtask

    task automatic t_reset();
        rd(`STP_ADDR_PWMCONF);
        chk("pwmconf reset", d, 32'hC40C_001D);
        chk("amp state", 32'(amp_state), 32'h0000_0001);
        wr(8'h3D, 32'hFFFF_FFFF);
        rd(8'h00);
        chk("unmapped read", d, 32'h0000_0000);
        rd(`STP_ADDR_PWMCONF);
        chk("pwmconf kept", d, 32'hC40C_001D);
        $display("test reset done");
    endtask

    task automatic t_fields();
        // write then read with no gap between the strobes
        @(posedge clk);
        addr <= `STP_ADDR_PWMCONF;
        wdata <= 32'h5A73_A5C3;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
        chk("pwmconf readback", d, 32'h5A73_A5C3);
        chk("slow decay measure", 32'(sd_meas), 32'h0000_0001);
        mot.set_state(1'b1, 1'b1, 1'b1, 1'b0);
        for (int m = 0; m < 4; m++) begin
            wr(`STP_ADDR_PWMCONF, 32'hC40C_001D | (m << 20));
            cyc(2);
            chk("hold mode", 32'(hold_mode), m);
        end
        mot.set_state(1'b1, 1'b1, 1'b0, 1'b0);
        cyc(2);
        chk("hold mode nonzero hold", 32'(hold_mode), 32'h0000_0000);
        wr(`STP_ADDR_PWMCONF, 32'hC48C_001D);
        cyc(2);
        chk("regulation suspended", 32'(reg_susp), 32'h0000_0001);
        mot.set_state(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(2);
        chk("regulation at run current", 32'(reg_susp), 32'h0000_0000);
        $display("test fields done");
    endtask

    // short: flag, bridge off, interrupt, and both ways of clearing
    task automatic t_short();
        wr(`STP_ADDR_IRQMASK, 32'h0000_0003);
        wr(`STP_ADDR_CTRL, 32'h0000_0005);
        cyc(2);
        chk("driver on", 32'(drv_en), 32'h0000_0001);
        mot.short_pulse();
        cyc(2);
        chk("driver off", 32'(drv_en), 32'h0000_0000);
        chk("irq raised", 32'(irq), 32'h0000_0001);
        wr(`STP_ADDR_CTRL, 32'h0000_0005);
        cyc(4);
        rd(`STP_ADDR_DRVSTAT);
        chk("short flag held", 32'(d[12]), 32'h0000_0001);
        wr(`STP_ADDR_IRQMASK, 32'h0000_0000);
        cyc(2);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        wr(`STP_ADDR_IRQMASK, 32'h0000_0003);
        wr(`STP_ADDR_IRQSTAT, 32'h0000_0001);
        cyc(2);
        chk("irq cleared", 32'(irq), 32'h0000_0000);
        wr(`STP_ADDR_CTRL, 32'h0000_0000);
        cyc(2);
        rd(`STP_ADDR_DRVSTAT);
        chk("flag off time zero", 32'(d[12]), 32'h0000_0000);
        wr(`STP_ADDR_CTRL, 32'h0000_0005);
        mot.short_pulse();
        wr(`STP_ADDR_CTRL, 32'h0000_0015);
        cyc(2);
        rd(`STP_ADDR_DRVSTAT);
        chk("flag disable bit", 32'(d[12]), 32'h0000_0000);
        chk("driver disabled", 32'(drv_en), 32'h0000_0000);
        wr(`STP_ADDR_IRQSTAT, 32'h0000_0003);
        $display("test short done");
    endtask

    // load result, stall, limits, quiet chopper, standstill on-time
    task automatic t_load();
        mot.set_state(1'b0, 1'b0, 1'b0, 1'b0);
        wr(`STP_ADDR_LIMITS, 32'h0200_0100);
        mot.send_load(10'h000);
        cyc(2);
        chk("stall", 32'(stall), 32'h0000_0001);
        rd(`STP_ADDR_DRVSTAT);
        chk("status stall", d & 32'h0100_03FF, 32'h0100_0000);
        rd(`STP_ADDR_IRQSTAT);
        chk("stall event", d, 32'h0000_0002);
        wr(`STP_ADDR_IRQSTAT, 32'h0000_0002);
        mot.send_load(10'h155);
        cyc(2);
        rd(`STP_ADDR_DRVSTAT);
        chk("load field", d & 32'h0100_03FF, 32'h0000_0155);
        mot.send_load(10'h050);
        cyc(2);
        chk("below limit", {ld_low, ld_high}, 32'h0000_0002);
        mot.send_load(10'h300);
        cyc(2);
        chk("above limit", {ld_low, ld_high}, 32'h0000_0001);
        mot.set_state(1'b0, 1'b0, 1'b0, 1'b1);
        mot.send_load(10'h000);
        cyc(2);
        chk("no stall in quiet mode", 32'(stall), 32'h0000_0000);
        mot.set_state(1'b1, 1'b0, 1'b0, 1'b0);
        cyc(3);
        rd(`STP_ADDR_DRVSTAT);
        chk("on-time at standstill", 32'(d[9:0]), 32'h0000_02A5);
        $display("test load done");
    endtask

    // amplitude cap, slope paths, gradient step, feed-forward
    task automatic t_amp();
        @(posedge clk);
        auto_amp <= 8'hF7;
        auto_slope <= 8'h11;
        wr(`STP_ADDR_PWMCONF, 32'h3204_F01D);
        pls(1'b0);
        cyc(2);
        chk("capped amplitude", 32'(amp), 32'h0000_0037);
        chk("user slope uncapped", 32'(slope), 32'h0000_00F0);
        @(posedge clk);
        auto_amp <= 8'h60;
        pls(1'b1);
        cyc(2);
        chk("gradient step", 32'(amp), 32'h0000_0038);
        wr(`STP_ADDR_PWMCONF, 32'h320C_F01D);
        cyc(2);
        chk("tuned slope", 32'(slope), 32'h0000_0011);
        @(posedge clk);
        cs <= 5'h1F;
        wr(`STP_ADDR_PWMCONF, 32'hC400_0040);
        cyc(3);
        chk("feed-forward", 32'(amp), 32'h0000_0040);
        chk("user state", 32'(amp_state), 32'h0000_0000);
        @(posedge clk);
        step_interval <= 20'h0_0010;
        wr(`STP_ADDR_PWMCONF, 32'hC400_10FF);
        cyc(3);
        chk("clamped amplitude", 32'(amp), 32'h0000_00FF);
        $display("test amplitude done");
    endtask

    // cycles until the next chopper tick
    task automatic gap(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 2000);
    endtask

    task automatic t_pwm();
        int div [4] = '{1024, 683, 512, 410};
        int g1;
        int g2;
        for (int k = 0; k < 4; k++) begin
            wr(`STP_ADDR_PWMCONF, 32'hC40C_001D | (k << 16));
            gap(g1);
            gap(g1);
            gap(g1);
            gap(g2);
            chk("pwm period", g1 + g2, div[k]);
        end
        $display("test pwm rate done");
    endtask

    // clock enable low freezes the registers; a mid-run reset brings back the defaults
    task automatic t_hold();
        @(posedge clk);
        ce <= 1'b0;
        wr(`STP_ADDR_PWMCONF, 32'h0000_0000);
        @(posedge clk);
        ce <= 1'b1;
        rd(`STP_ADDR_PWMCONF);
        chk("frozen write", d, 32'hC40F_001D);
        wr(`STP_ADDR_PWMCONF, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        rd(`STP_ADDR_PWMCONF);
        chk("pwmconf after reset", d, 32'hC40C_001D);
        chk("driver after reset", 32'(drv_en), 32'h0000_0000);
        $display("test hold and reset done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_short();
        t_load();
        t_amp();
        t_pwm();
        t_hold();
        give_verdict();
    end
endmodule
